// >>> rtl/aspc_pkg.sv
package aspc_pkg;

  // Register addresses
  localparam logic [15:0] ADDR_MODE   = 16'hff90;
  localparam logic [15:0] ADDR_ERRST  = 16'hff94;
  localparam logic [15:0] ADDR_TXST   = 16'hff95;
  localparam logic [15:0] ADDR_TXBUF  = 16'hff96;
  localparam logic [15:0] ADDR_RXBUF  = 16'hff97;

  // Mode register fields
  localparam int MODE_POWER  = 7;
  localparam int MODE_TXE    = 6;
  localparam int MODE_RXE    = 5;
  localparam int MODE_PS_HI  = 4;
  localparam int MODE_PS_LO  = 3;
  localparam int MODE_LEN    = 2;
  localparam int MODE_STOP   = 1;
  localparam int MODE_ERRTE  = 0;

  // Receive error status fields
  localparam int ERR_PE  = 2;
  localparam int ERR_FE  = 1;
  localparam int ERR_OVE = 0;

  // Transmit status fields
  localparam int TXST_FULL = 1;
  localparam int TXST_BUSY = 0;

  // Reset values
  localparam logic [7:0] MODE_RST  = 8'h00;
  localparam logic [7:0] TXBUF_RST = 8'hff;
  localparam logic [7:0] RXBUF_RST = 8'hff;
  localparam logic [7:0] STAT_RST  = 8'h00;

  // Parity select encodings
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_ODD  = 2'h2;
  localparam logic [1:0] PAR_EVEN = 2'h3;

  // Oversample ratio and IrDA pulse in oversample ticks, frame width in bits
  localparam int OVS_DEF    = 16;
  localparam int IRDA_PULSE = 3;
  localparam int FRAME_W    = 12;

endpackage : aspc_pkg

// >>> rtl/aspc_buf.sv
`timescale 1ns/100ps
`default_nettype none
module aspc_buf #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             nrst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH != 2 && DEPTH != 4) begin : g_chk
    $error("aspc_buf: DEPTH must be 2 or 4");
  end

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;

  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  assign in_ready  = (count_ff != (AW+1)'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign out_data  = mem_ff[rd_ptr_ff];

  always_ff @(posedge clock) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end

endmodule : aspc_buf
`default_nettype wire

// >>> rtl/aspc_core.sv
`timescale 1ns/100ps
`default_nettype none
module aspc_core
  import aspc_pkg::*;
#(
  parameter int OVERSAMPLE = OVS_DEF
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // Register port
  input  wire logic        cpu_wr,
  input  wire logic        cpu_rd,
  input  wire logic [15:0] cpu_addr,
  input  wire logic [7:0]  cpu_wdata,
  input  wire logic [7:0]  cpu_wmask,
  output logic [7:0]       cpu_rdata,
  // Serial timing and mode
  input  wire logic        os_tick,
  input  wire logic        irda_mode,
  // Serial pins
  input  wire logic        serial_in_pin,
  output logic             serial_out_pin,
  // Events
  output logic             receive_complete_irq,
  output logic             receive_error_irq
);

  if (OVERSAMPLE < 4 || OVERSAMPLE > 16) begin : g_chk
    $error("aspc_core: OVERSAMPLE must be 4..16");
  end

  localparam logic [3:0] OS_LAST = 4'(OVERSAMPLE - 1);
  localparam logic [3:0] OS_MID  = 4'(OVERSAMPLE / 2 - 1);
  localparam logic [3:0] OS_IRDA = 4'(IRDA_PULSE);

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } aspc_rx_t;

  // Registers
  logic [7:0]         serial_mode_control_ff;
  logic [7:0]         transmit_buffer_ff;
  logic [7:0]         receive_buffer_ff;
  logic               rxb_full_ff;
  logic               tx_buffer_full_flag_ff;
  logic               tx_shifter_busy_flag_ff;
  logic [FRAME_W-1:0] tx_shift_reg_ff;
  logic [3:0]         tx_left_ff;
  logic [3:0]         tx_os_ff;
  logic               serial_out_pin_ff;
  aspc_rx_t           rx_state_ff;
  logic [3:0]         rx_os_ff;
  logic [3:0]         rx_cnt_ff;
  logic [8:0]         rx_shift_reg_ff;
  logic               parity_error_flag_ff;
  logic               framing_error_flag_ff;
  logic               overrun_error_flag_ff;
  logic               rx_done_irq_ff;
  logic               rx_err_irq_ff;
  logic [7:0]         cpu_rdata_ff;

  // Mode decode
  wire       power_clock_enable  = serial_mode_control_ff[MODE_POWER];
  wire       transmit_enable_bit = serial_mode_control_ff[MODE_TXE];
  wire       receive_enable_bit  = serial_mode_control_ff[MODE_RXE];
  wire [1:0] parity_sel =
    serial_mode_control_ff[MODE_PS_HI:MODE_PS_LO];
  wire       char_length_bit     = serial_mode_control_ff[MODE_LEN];
  wire       stop_bits_select    = serial_mode_control_ff[MODE_STOP];
  wire       error_irq_routing   = serial_mode_control_ff[MODE_ERRTE];
  wire       tx_on = power_clock_enable & transmit_enable_bit;
  wire       rx_on = power_clock_enable & receive_enable_bit;
  wire       has_par = (parity_sel != PAR_NONE);

  // Address decode
  wire sel_mode  = (cpu_addr == ADDR_MODE);
  wire sel_errst = (cpu_addr == ADDR_ERRST);
  wire sel_txst  = (cpu_addr == ADDR_TXST);
  wire sel_txbuf = (cpu_addr == ADDR_TXBUF);
  wire sel_rxbuf = (cpu_addr == ADDR_RXBUF);

  wire wr_mode = cpu_wr & sel_mode;
  wire [7:0] nxt_mode =
    (serial_mode_control_ff & ~cpu_wmask) | (cpu_wdata & cpu_wmask);
  wire wr_txbuf = cpu_wr & sel_txbuf & tx_on
                & ~tx_buffer_full_flag_ff;
  wire rd_rxbuf  = cpu_rd & sel_rxbuf;
  wire rd_errst  = cpu_rd & sel_errst;

  // Transmit frame assembly
  wire [7:0] tx_data = char_length_bit ? transmit_buffer_ff
                                       : {1'b0, transmit_buffer_ff[6:0]};
  wire       tx_par_odd = ~^tx_data;
  wire       tx_par_bit = (parity_sel == PAR_ODD)  ? tx_par_odd :
                          (parity_sel == PAR_EVEN) ? ~tx_par_odd :
                          1'b0;
  wire [3:0] len_bits = char_length_bit ? 4'h8 : 4'h7;
  wire [3:0] tx_nbits = 4'h1 + len_bits + {3'h0, has_par}
                      + (stop_bits_select ? 4'h2 : 4'h1);

  logic [FRAME_W-1:0] nxt_frame;
  always_comb begin
    nxt_frame = {FRAME_W{1'b1}};
    nxt_frame[0] = 1'b0;
    nxt_frame[7:1] = tx_data[6:0];
    if (char_length_bit) begin
      nxt_frame[8] = tx_data[7];
    end
    if (has_par) begin
      nxt_frame[len_bits+4'h1] = tx_par_bit;
    end
  end

  wire tx_load = tx_on & tx_buffer_full_flag_ff
               & ~tx_shifter_busy_flag_ff;
  wire tx_bit_end = tx_shifter_busy_flag_ff & os_tick
                  & (tx_os_ff == OS_LAST);
  wire tx_last = tx_bit_end & (tx_left_ff == 4'h1);
  wire tx_line = tx_shifter_busy_flag_ff ? tx_shift_reg_ff[0] : 1'b1;
  wire irda_out = ~tx_line & tx_shifter_busy_flag_ff
                & (tx_os_ff < OS_IRDA);
  wire nxt_pin = ~power_clock_enable ? 1'b0 :
                 irda_mode ? irda_out : tx_line;

  // Mode register
  always_ff @(posedge clock) begin
    if (!nrst) begin
      serial_mode_control_ff <= MODE_RST;
    end else if (wr_mode) begin
      serial_mode_control_ff <= nxt_mode;
    end
  end

  // Transmit buffer and full flag
  always_ff @(posedge clock) begin
    if (!nrst) begin
      transmit_buffer_ff <= TXBUF_RST;
    end else if (wr_txbuf) begin
      transmit_buffer_ff <= cpu_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst || !tx_on) begin
      tx_buffer_full_flag_ff <= 1'b0;
    end else if (wr_txbuf) begin
      tx_buffer_full_flag_ff <= 1'b1;
    end else if (tx_load) begin
      tx_buffer_full_flag_ff <= 1'b0;
    end
  end

  // Transmit shifter
  always_ff @(posedge clock) begin
    if (!nrst || !tx_on) begin
      tx_shift_reg_ff         <= {FRAME_W{1'b1}};
      tx_shifter_busy_flag_ff <= 1'b0;
      tx_left_ff              <= 4'h0;
      tx_os_ff                <= 4'h0;
    end else if (tx_load) begin
      tx_shift_reg_ff         <= nxt_frame;
      tx_shifter_busy_flag_ff <= 1'b1;
      tx_left_ff              <= tx_nbits;
      tx_os_ff                <= 4'h0;
    end else if (tx_bit_end) begin
      tx_shift_reg_ff <= {1'b1, tx_shift_reg_ff[FRAME_W-1:1]};
      tx_left_ff      <= tx_left_ff - 4'h1;
      tx_os_ff        <= 4'h0;
      if (tx_last) begin
        tx_shifter_busy_flag_ff <= 1'b0;
      end
    end else if (tx_shifter_busy_flag_ff && os_tick) begin
      tx_os_ff <= tx_os_ff + 4'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      serial_out_pin_ff <= 1'b0;
    end else begin
      serial_out_pin_ff <= nxt_pin;
    end
  end

  // Receive controller
  wire [3:0] rx_need = len_bits + {3'h0, has_par};
  wire       rx_mid  = os_tick & (rx_os_ff == OS_MID);
  wire       rx_end  = os_tick & (rx_os_ff == OS_LAST);
  wire       rx_done = (rx_state_ff == RX_STOP) & rx_end;
  wire [8:0] rx_align = rx_shift_reg_ff >> (4'h9 - rx_need);
  wire [7:0] rx_data = char_length_bit ? rx_align[7:0]
                                       : {1'b0, rx_align[6:0]};
  wire       rx_par  = char_length_bit ? rx_align[8] : rx_align[7];
  wire       rx_xor  = ^{rx_data, rx_par};
  wire       rx_pe   = ((parity_sel == PAR_ODD) & ~rx_xor)
                     | ((parity_sel == PAR_EVEN) & rx_xor);
  wire       rx_fe   = ~serial_in_pin;

  logic       buf_in_ready;
  logic       buf_out_valid;
  logic [9:0] buf_out_data;
  wire        buf_push = rx_done & buf_in_ready;
  wire        rx_ovr   = rx_done & ~buf_in_ready;
  wire        buf_pop  = buf_out_valid & ~rxb_full_ff;
  wire        buf_nrst = nrst & rx_on;
  wire        rx_err   = rx_done & (rx_pe | rx_fe | rx_ovr);

  always_ff @(posedge clock) begin
    if (!nrst || !rx_on) begin
      rx_state_ff     <= RX_IDLE;
      rx_os_ff        <= 4'h0;
      rx_cnt_ff       <= 4'h0;
      rx_shift_reg_ff <= 9'h1ff;
    end else begin
      case (rx_state_ff)
        RX_IDLE: begin
          rx_os_ff <= 4'h0;
          if (os_tick && !serial_in_pin) begin
            rx_state_ff <= RX_START;
          end
        end
        RX_START: begin
          if (rx_mid) begin
            rx_os_ff  <= 4'h0;
            rx_cnt_ff <= 4'h0;
            rx_state_ff <= serial_in_pin ? RX_IDLE : RX_DATA;
          end else if (os_tick) begin
            rx_os_ff <= rx_os_ff + 4'h1;
          end
        end
        RX_DATA: begin
          if (rx_end) begin
            rx_os_ff <= 4'h0;
            rx_shift_reg_ff <= {serial_in_pin,
                                rx_shift_reg_ff[8:1]};
            rx_cnt_ff <= rx_cnt_ff + 4'h1;
            if (rx_cnt_ff == rx_need - 4'h1) begin
              rx_state_ff <= RX_STOP;
            end
          end else if (os_tick) begin
            rx_os_ff <= rx_os_ff + 4'h1;
          end
        end
        RX_STOP: begin
          if (rx_end) begin
            rx_os_ff    <= 4'h0;
            rx_state_ff <= RX_IDLE;
          end else if (os_tick) begin
            rx_os_ff <= rx_os_ff + 4'h1;
          end
        end
        default: begin
          rx_state_ff <= RX_IDLE;
        end
      endcase
    end
  end

  aspc_buf #(
    .WIDTH (10),
    .DEPTH (2)
  ) u_rx_buf (
    .clock     (clock),
    .nrst      (buf_nrst),
    .in_valid  (buf_push),
    .in_ready  (buf_in_ready),
    .in_data   ({rx_pe, rx_fe, rx_data}),
    .out_valid (buf_out_valid),
    .out_ready (~rxb_full_ff),
    .out_data  (buf_out_data)
  );

  // Receive buffer register
  always_ff @(posedge clock) begin
    if (!nrst || !power_clock_enable) begin
      receive_buffer_ff <= RXBUF_RST;
      rxb_full_ff       <= 1'b0;
    end else if (buf_pop) begin
      receive_buffer_ff <= buf_out_data[7:0];
      rxb_full_ff       <= 1'b1;
    end else if (rd_rxbuf) begin
      rxb_full_ff <= 1'b0;
    end
  end

  // Error status: set wins over read clear
  always_ff @(posedge clock) begin
    if (!nrst || !power_clock_enable) begin
      parity_error_flag_ff  <= 1'b0;
      framing_error_flag_ff <= 1'b0;
      overrun_error_flag_ff <= 1'b0;
    end else begin
      parity_error_flag_ff <= (rx_done & rx_pe)
        | (parity_error_flag_ff & ~rd_errst);
      framing_error_flag_ff <= (rx_done & rx_fe)
        | (framing_error_flag_ff & ~rd_errst);
      overrun_error_flag_ff <= rx_ovr
        | (overrun_error_flag_ff & ~rd_errst);
    end
  end

  // Event routing
  always_ff @(posedge clock) begin
    if (!nrst || !rx_on) begin
      rx_done_irq_ff <= 1'b0;
      rx_err_irq_ff  <= 1'b0;
    end else begin
      rx_done_irq_ff <= rx_done & ~(rx_err & error_irq_routing);
      rx_err_irq_ff  <= rx_err & error_irq_routing;
    end
  end

  // Read data
  wire [7:0] errst_val = {5'h00, parity_error_flag_ff,
                          framing_error_flag_ff, overrun_error_flag_ff};
  wire [7:0] txst_val  = {6'h00, tx_buffer_full_flag_ff,
                          tx_shifter_busy_flag_ff};
  wire [7:0] rd_val = sel_mode  ? serial_mode_control_ff :
                      sel_errst ? errst_val :
                      sel_txst  ? txst_val :
                      sel_rxbuf ? receive_buffer_ff :
                      8'h00;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      cpu_rdata_ff <= STAT_RST;
    end else if (cpu_rd) begin
      cpu_rdata_ff <= rd_val;
    end
  end

  assign cpu_rdata            = cpu_rdata_ff;
  assign serial_out_pin       = serial_out_pin_ff;
  assign receive_complete_irq = rx_done_irq_ff;
  assign receive_error_irq    = rx_err_irq_ff;

endmodule : aspc_core
`default_nettype wire

// >>> verif/aspc_core_props.sv
`timescale 1ns/100ps
`default_nettype none
module aspc_core_props
  import aspc_pkg::*;
#(
  parameter int OVERSAMPLE = OVS_DEF
) (
  // Clock and reset
  input wire logic        clock,
  input wire logic        nrst,
  // Register port
  input wire logic        cpu_wr,
  input wire logic        cpu_rd,
  input wire logic [15:0] cpu_addr,
  input wire logic [7:0]  cpu_wdata,
  input wire logic [7:0]  cpu_wmask,
  input wire logic [7:0]  cpu_rdata,
  // Timing, pins and events
  input wire logic        os_tick,
  input wire logic        irda_mode,
  input wire logic        serial_in_pin,
  input wire logic        serial_out_pin,
  input wire logic        receive_complete_irq,
  input wire logic        receive_error_irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  // Shadow of the mode register
  logic [7:0] mode_ff;
  logic [7:0] nxt_mode;
  assign nxt_mode = (cpu_wr && cpu_addr == ADDR_MODE)
    ? ((mode_ff & ~cpu_wmask) | (cpu_wdata & cpu_wmask)) : mode_ff;
  always_ff @(posedge clock) begin
    if (!nrst) mode_ff <= MODE_RST;
    else mode_ff <= nxt_mode;
  end
  wire pwr = mode_ff[MODE_POWER];
  wire txe = mode_ff[MODE_TXE];
  wire rxe = mode_ff[MODE_RXE];

  // Settled states
  sequence pwr_off_s; !pwr [*3]; endsequence
  sequence quiet_s; (pwr && !txe && !irda_mode) [*3]; endsequence
  sequence ir_quiet_s; (pwr && !txe && irda_mode) [*3]; endsequence
  sequence rx_off_s; !rxe [*3]; endsequence

  pin_off_low_a: assert property (pwr_off_s |-> !serial_out_pin)
    else $error("transmit pin not low while powered off");
  pin_idle_high_a: assert property (quiet_s |-> serial_out_pin)
    else $error("transmit pin not idle high");
  ir_idle_low_a: assert property (ir_quiet_s |-> !serial_out_pin)
    else $error("infrared transmit pin not idle low");
  ir_pulse_a: assert property ($past(irda_mode) && $past(pwr)
    && !$past(txe, 2) |-> !serial_out_pin)
    else $error("infrared pulse without transmit enable");
  mode_read_a: assert property (cpu_rd && cpu_addr == ADDR_MODE
    |=> cpu_rdata == $past(mode_ff))
    else $error("mode register readback wrong");
  rxbuf_off_a: assert property (pwr_off_s ##0
    (cpu_rd && cpu_addr == ADDR_RXBUF) |=> cpu_rdata == RXBUF_RST)
    else $error("receive buffer not all ones while powered off");
  txst_off_a: assert property ((!txe) [*3] ##0
    (cpu_rd && cpu_addr == ADDR_TXST) |=> cpu_rdata[1:0] == 2'h0)
    else $error("transmit flags set while transmit disabled");
  err_route_a: assert property (receive_error_irq
    |-> mode_ff[MODE_ERRTE] && !receive_complete_irq)
    else $error("error event on wrong route");
  done_pulse_a: assert property (receive_complete_irq
    |=> !receive_complete_irq)
    else $error("receive event longer than one cycle");
  rx_off_quiet_a: assert property (rx_off_s
    |-> !receive_complete_irq && !receive_error_irq)
    else $error("receive event while reception disabled");
endmodule : aspc_core_props

bind aspc_core aspc_core_props #(.OVERSAMPLE(OVERSAMPLE)) u_props (
  .clock(clock), .nrst(nrst), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
  .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wmask(cpu_wmask),
  .cpu_rdata(cpu_rdata), .os_tick(os_tick), .irda_mode(irda_mode),
  .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
  .receive_complete_irq(receive_complete_irq),
  .receive_error_irq(receive_error_irq));
`default_nettype wire

// >>> verif/aspc_remote.sv
`timescale 1ns/100ps
`default_nettype none
module aspc_remote #(
  parameter int BIT_CLKS = 8
) (
  // Clock
  input  wire logic clock,
  // Serial lines
  input  wire logic line_in,
  output logic      line_out
);
  initial line_out = 1'b1;

  // One frame: start, data LSB first, parity, one stop
  task automatic send(input logic [7:0] d, input logic [4:0] f,
                      input logic bad_par, input logic bad_stop);
    logic [11:0] v;
    int          n;
    v = '1;
    v[0] = 1'b0;
    n = f[2] ? 9 : 8;
    for (int i = 1; i < n; i++) v[i] = d[i-1];
    if (f[4:3] != 2'h0) begin
      v[n] = (f[4:3] == 2'h1) ? 1'b0 : (^d[6:0] ^ (f[2] & d[7]) ^ !f[3]);
      v[n] = v[n] ^ bad_par;
      n++;
    end
    v[n] = !bad_stop;
    for (int i = 0; i <= n; i++) begin
      @(posedge clock);
      line_out <= v[i];
      repeat (BIT_CLKS - 1) @(posedge clock);
    end
    @(posedge clock);
    line_out <= 1'b1;
  endtask : send

  // Samples n bits mid-bit from the next start edge
  task automatic grab(input int n, output logic [11:0] v, output logic ok);
    int w;
    v = '1;
    ok = 1'b0;
    w = 0;
    while (line_in !== 1'b0 && w < 40 * BIT_CLKS) begin
      @(posedge clock);
      w++;
    end
    if (line_in === 1'b0) begin
      ok = 1'b1;
      repeat (BIT_CLKS / 2) @(posedge clock);
      for (int i = 0; i < n; i++) begin
        v[i] = line_in;
        if (i < n - 1) repeat (BIT_CLKS) @(posedge clock);
      end
    end
  endtask : grab
endmodule : aspc_remote
`default_nettype wire

// >>> verif/aspc_core_tb.sv
`timescale 1ns/100ps
`default_nettype none
module aspc_core_tb
  import aspc_pkg::*;
;
  localparam int OVS  = 4;
  localparam int BITC = 2 * OVS;

  logic        clock;
  logic        nrst;
  logic        cpu_wr;
  logic        cpu_rd;
  logic [15:0] cpu_addr;
  logic [7:0]  cpu_wdata;
  logic [7:0]  cpu_wmask;
  logic [7:0]  cpu_rdata;
  logic        os_tick;
  logic        irda_mode;
  logic        rx_line;
  logic        tx_line;
  logic        done_irq;
  logic        err_irq;
  int          miscompares = 0;
  int          checked = 0;
  int          n_done = 0;
  int          n_err = 0;

  typedef struct packed {
    logic [4:0] f;
    logic [7:0] d;
    logic       bp;
    logic       bs;
    logic [7:0] rx;
    logic [7:0] st;
    logic       ei;
  } aspc_row_t;

  // Mode fields, data, bad parity, bad stop, rx buffer, status, error event
  aspc_row_t rows [7] = '{
    '{5'h04, 8'ha5, 1'b0, 1'b0, 8'ha5, 8'h00, 1'b0},
    '{5'h16, 8'h3c, 1'b0, 1'b0, 8'h3c, 8'h00, 1'b0},
    '{5'h19, 8'hd9, 1'b0, 1'b0, 8'h59, 8'h00, 1'b0},
    '{5'h0f, 8'h81, 1'b1, 1'b0, 8'h81, 8'h00, 1'b0},
    '{5'h15, 8'h5a, 1'b1, 1'b0, 8'h5a, 8'h04, 1'b1},
    '{5'h1c, 8'h0f, 1'b1, 1'b0, 8'h0f, 8'h04, 1'b0},
    '{5'h05, 8'h77, 1'b0, 1'b1, 8'h77, 8'h02, 1'b1}};

  aspc_core #(.OVERSAMPLE(OVS)) dut (
    .clock(clock), .nrst(nrst), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wmask(cpu_wmask),
    .cpu_rdata(cpu_rdata), .os_tick(os_tick), .irda_mode(irda_mode),
    .serial_in_pin(rx_line), .serial_out_pin(tx_line),
    .receive_complete_irq(done_irq), .receive_error_irq(err_irq));
  aspc_remote #(.BIT_CLKS(BITC)) u_remote (
    .clock(clock), .line_in(tx_line), .line_out(rx_line));

  always #4 clock = ~clock;
  always @(posedge clock) os_tick <= ~os_tick;
  always @(posedge clock) begin
    if (done_irq === 1'b1) n_done++;
    if (err_irq === 1'b1) n_err++;
  end

  function automatic logic [11:0] frame(input logic [4:0] f,
                                        input logic [7:0] d);
    logic [11:0] v;
    int          k;
    v = '1;
    v[0] = 1'b0;
    k = f[2] ? 8 : 7;
    for (int i = 0; i < k; i++) v[i+1] = d[i];
    if (f[4:3] != 2'h0)
      v[k+1] = (f[4:3] == 2'h1) ? 1'b0 : (^d[6:0] ^ (f[2] & d[7]) ^ !f[3]);
    return v;
  endfunction : frame

  task automatic chk(input string nm, input logic [11:0] e,
                     input logic [11:0] s);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic acc(input logic w, input logic [15:0] a,
                     input logic [7:0] d, input logic [7:0] m);
    @(posedge clock);
    cpu_wr <= w;
    cpu_rd <= !w;
    cpu_addr <= a;
    cpu_wdata <= d;
    cpu_wmask <= m;
    @(posedge clock);
    cpu_wr <= 1'b0;
    cpu_rd <= 1'b0;
  endtask : acc

  task automatic rc(input logic [15:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00, 8'h00);
    @(posedge clock);
    #1;
    chk("rdata", {4'h0, e}, {4'h0, cpu_rdata});
  endtask : rc

  task automatic wrap_up;
    if (miscompares == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    wrap_up();
  end

  initial begin
    logic [11:0] fr;
    logic        ok;
    int          c0;
    int          e0;
    clock = 1'b0;
    nrst = 1'b0;
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
    cpu_addr = 16'h0000;
    cpu_wdata = 8'h00;
    cpu_wmask = 8'h00;
    os_tick = 1'b0;
    irda_mode = 1'b0;
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    chk("pin", 12'h000, {11'h0, tx_line});
    rc(ADDR_MODE, 8'h00);
    rc(ADDR_RXBUF, 8'hff);
    rc(ADDR_TXST, 8'h00);
    rc(ADDR_ERRST, 8'h00);
    acc(1'b1, ADDR_RXBUF, 8'h00, 8'hff);
    rc(ADDR_RXBUF, 8'hff);
    rc(16'hff98, 8'h00);
    acc(1'b1, ADDR_MODE, 8'hff, 8'h01);
    acc(1'b1, ADDR_MODE, 8'h80, 8'h80);
    rc(ADDR_MODE, 8'h81);
    acc(1'b1, ADDR_MODE, 8'hc4, 8'hff);
    repeat (2 * BITC) @(posedge clock);
    fork
      begin
        u_remote.grab(10, fr, ok);
        chk("frame1", frame(5'h04, 8'h11), fr);
        u_remote.grab(10, fr, ok);
        chk("frame2", frame(5'h04, 8'h33), fr);
        u_remote.grab(10, fr, ok);
        chk("extra", 12'h000, {11'h0, ok});
      end
      begin
        acc(1'b1, ADDR_TXBUF, 8'h11, 8'hff);
        repeat (4) @(posedge clock);
        acc(1'b1, ADDR_TXBUF, 8'h33, 8'hff);
        acc(1'b1, ADDR_TXBUF, 8'h44, 8'hff);
        rc(ADDR_TXST, 8'h03);
      end
    join
    rc(ADDR_TXST, 8'h00);
    foreach (rows[i]) begin
      acc(1'b1, ADDR_MODE, 8'h80, 8'hff);
      acc(1'b1, ADDR_MODE, {3'b111, rows[i].f}, 8'hff);
      repeat (2 * BITC) @(posedge clock);
      c0 = n_done;
      e0 = n_err;
      fork
        u_remote.send(rows[i].d, rows[i].f, rows[i].bp, rows[i].bs);
        begin
          acc(1'b1, ADDR_TXBUF, rows[i].d, 8'hff);
          u_remote.grab((rows[i].f[2] ? 9 : 8) + (rows[i].f[1] ? 2 : 1)
            + int'(rows[i].f[4:3] != 2'h0), fr, ok);
        end
      join
      repeat (2 * BITC) @(posedge clock);
      chk("frame", frame(rows[i].f, rows[i].d), fr);
      chk("err_irq", 12'(rows[i].ei), 12'(n_err - e0));
      chk("done_irq", 12'(!rows[i].ei), 12'(n_done - c0));
      rc(ADDR_ERRST, rows[i].st);
      rc(ADDR_RXBUF, rows[i].rx);
    end
    acc(1'b1, ADDR_MODE, 8'h80, 8'hff);
    acc(1'b1, ADDR_MODE, 8'ha4, 8'hff);
    repeat (2 * BITC) @(posedge clock);
    for (int i = 1; i <= 4; i++)
      u_remote.send(8'(i * 17), 5'h04, 1'b0, 1'b0);
    repeat (BITC) @(posedge clock);
    rc(ADDR_ERRST, 8'h01);
    rc(ADDR_RXBUF, 8'h11);
    @(posedge clock) irda_mode <= 1'b1;
    repeat (4) @(posedge clock);
    chk("irda_pin", 12'h000, {11'h0, tx_line});
    acc(1'b1, ADDR_MODE, 8'hc4, 8'hff);
    repeat (2 * BITC) @(posedge clock);
    acc(1'b1, ADDR_TXBUF, 8'h00, 8'hff);
    c0 = 0;
    e0 = 0;
    repeat (12 * BITC) begin
      @(posedge clock);
      c0 += int'(tx_line && e0 == 0);
      e0 = int'(tx_line);
    end
    chk("irda_pulses", 12'h009, 12'(c0));
    irda_mode <= 1'b0;
    acc(1'b1, ADDR_MODE, 8'h80, 8'hff);
    repeat (2 * BITC) @(posedge clock);
    acc(1'b1, ADDR_MODE, 8'h00, 8'hff);
    repeat (2) @(posedge clock);
    rc(ADDR_RXBUF, 8'hff);
    chk("off_pin", 12'h000, {11'h0, tx_line});
    wrap_up();
  end
endmodule : aspc_core_tb
`default_nettype wire
